// ### rtccr_pkg.sv
package rtccr_pkg;

  // ==========================================================
  // Register map (byte addresses on the register bus)
  // ==========================================================
  localparam logic [3:0] CTRL_OFS = 4'h0; // Control register
  localparam logic [3:0] TIME_OFS = 4'h4; // Time of day register

  // ==========================================================
  // Control register field positions
  // ==========================================================
  localparam int TRIM_LSB = 16;  // Drift trim, 10 bits signed
  localparam int TRIM_W = 10;    // Drift trim width
  localparam int ON_BIT = 15;    // Module enable
  localparam int STOP_WHEN_IDLE_BIT = 13;  // Stop when idle
  localparam int OSEL_BIT = 7;   // Output source select
  localparam int RUN_BIT = 6;    // Timebase running, read only
  localparam int UNLK_BIT = 3;   // Write unlock flag
  localparam int SYNC_BIT = 2;   // Rollover pending, read only
  localparam int HALF_BIT = 1;   // Half second phase, read only
  localparam int OE_BIT = 0;     // Output pin enable

  // Writable bits of the control register
  // Trim 25:16, enable 15, idle stop 13, select 7, unlock 3, pin enable 0
  localparam logic [31:0] CTRL_WMASK = 32'h03FF_A089;

  // ==========================================================
  // Reset values and timing
  // ==========================================================
  localparam logic [31:0] CTRL_RST = 32'h0000_0000; // After power-on
  localparam logic [31:0] TIME_RST = 32'h0000_0000; // After power-on
  localparam int SEC_LSB = 8;    // Seconds fields in time register
  localparam int SEC_MSB = 14;   // Top of seconds fields
  localparam int HALVES_PER_MIN = 120; // Half seconds in one minute
  localparam int SYNC_TICKS = 32; // Rollover warning window, ticks

  // ==========================================================
  // Bus answers
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;   // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

endpackage

// ### rtccr_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Positive trim adds that many pulses per minute
// - Negative trim removes pulses, minimum removes 512
// - Enable bit writable only while unlock set
// - Stop-when-idle freezes the timebase during Idle
// - Select bit routes seconds clock or alarm
// - Output pin active only when output enabled
// - Running bit shows timebase running: enabled, source active, not frozen
// - Unlock flag sets only after system sequence
// - Half second bit cleared on seconds write
// - Control register reset by power-on only
// - Unimplemented control bits read zero always
module rtccr_top #(
  parameter int TICKS_HALF = 16384 // Timebase ticks per half second
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WARM_RST,
  input wire logic IDLE_MODE,
  input wire logic SYS_SEQ_OPEN,
  input wire logic TB_SRC_ACTIVE,
  input wire logic TB_TICK,
  input wire logic ALARM_PULSE,
  output logic RTC_PIN,
  output logic TIMEBASE_TICK,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [31:0] ctrl_reg;      // Stored writable control bits
  logic [31:0] time_reg;      // Time of day storage
  logic [3:0] awaddr_reg;     // Latched write address
  logic aw_full_reg;          // Write address held
  logic [31:0] wdata_reg;     // Latched write data
  logic [3:0] wstrb_reg;      // Latched byte enables
  logic w_full_reg;           // Write data held
  logic bvalid_reg;           // Write answer pending
  logic [1:0] bresp_reg;      // Write answer code
  logic rvalid_reg;           // Read answer pending
  logic [1:0] rresp_reg;      // Read answer code
  logic [31:0] rdata_reg;     // Read answer data
  logic do_write;             // Address and data both present
  logic [31:0] wmask;         // Byte enables widened to bits
  logic [31:0] ctrl_next;     // Control value after a write
  logic [31:0] ctrl_view;     // Control value as read back
  logic on_bit;               // Module enabled
  logic frozen;               // Clock gated by idle stop
  logic run;                  // Timebase advancing
  logic tick_in;              // Raw tick allowed through
  logic eff_tick;             // Tick after trim correction
  logic [9:0] add_cnt_reg;    // Pulses still to insert
  logic [9:0] sub_cnt_reg;    // Pulses still to swallow
  logic [31:0] pre_reg;       // Ticks within half second
  logic [6:0] halves_reg;     // Half seconds within minute
  logic half_reg;             // Half second phase
  logic half_wrap;            // Half second boundary
  logic min_wrap;             // Minute boundary
  logic sync_flag;            // Rollover imminent
  logic [9:0] trim;           // Signed drift trim
  logic sec_write;            // Seconds fields being written
  // Start of the warning window; a short half second is all window
  localparam int SYNC_FROM = (TICKS_HALF > rtccr_pkg::SYNC_TICKS) ?
    (TICKS_HALF - rtccr_pkg::SYNC_TICKS) : 0;

  // ==========================================================
  // Register bus write channels
  // ==========================================================
  assign S_AXI_AWREADY = ~aw_full_reg;
  assign S_AXI_WREADY = ~w_full_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  // A write proceeds once both halves are held and answer is free
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;

  // Latch write address; released after the write commits
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST)
    begin
      aw_full_reg <= 1'b0;
      awaddr_reg <= 4'h0;
    end
    else if (S_AXI_AWVALID & ~aw_full_reg)
    begin
      aw_full_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR;
    end
    else if (do_write)
    begin
      aw_full_reg <= 1'b0;
    end
  end

  // Latch write data independently of the address
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST)
    begin
      w_full_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (S_AXI_WVALID & ~w_full_reg)
    begin
      w_full_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end
    else if (do_write)
    begin
      w_full_reg <= 1'b0;
    end
  end

  // Write answer; unmapped addresses get a slave error
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= rtccr_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      if ((awaddr_reg == rtccr_pkg::CTRL_OFS) |
          (awaddr_reg == rtccr_pkg::TIME_OFS))
        bresp_reg <= rtccr_pkg::RESP_OKAY;
      else
        bresp_reg <= rtccr_pkg::RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Control register write path
  // ==========================================================
  // Widen byte enables into a bit mask
  always_comb
  begin
    wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
             {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  end

  // Merge a write into the stored bits, honouring locks
  always_comb
  begin
    ctrl_next = (ctrl_reg & ~(wmask & rtccr_pkg::CTRL_WMASK)) |
                (wdata_reg & wmask & rtccr_pkg::CTRL_WMASK);
    // Enable keeps its old value unless already unlocked
    if (~ctrl_reg[rtccr_pkg::UNLK_BIT])
      ctrl_next[rtccr_pkg::ON_BIT] = ctrl_reg[rtccr_pkg::ON_BIT];
    // Unlock may always be cleared, set only with sequence open
    if (~SYS_SEQ_OPEN & ~ctrl_reg[rtccr_pkg::UNLK_BIT])
      ctrl_next[rtccr_pkg::UNLK_BIT] = 1'b0;
  end

  // Control store: only power-on reset clears it, warm reset not
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ctrl_reg <= rtccr_pkg::CTRL_RST;
    else if (do_write & (awaddr_reg == rtccr_pkg::CTRL_OFS))
      ctrl_reg <= ctrl_next;
  end

  // Time register storage, plain read-write word
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      time_reg <= rtccr_pkg::TIME_RST;
    else if (do_write & (awaddr_reg == rtccr_pkg::TIME_OFS))
      time_reg <= (time_reg & ~wmask) | (wdata_reg & wmask);
  end

  // Seconds fields sit in byte lane 1 of the time register
  assign sec_write = do_write & (awaddr_reg == rtccr_pkg::TIME_OFS) &
                     wstrb_reg[rtccr_pkg::SEC_MSB / 8];

  // ==========================================================
  // Register bus read channel
  // ==========================================================
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // Read view: stored bits plus live status, gaps read zero
  always_comb
  begin
    ctrl_view = ctrl_reg & rtccr_pkg::CTRL_WMASK;
    ctrl_view[rtccr_pkg::RUN_BIT] = run;
    ctrl_view[rtccr_pkg::SYNC_BIT] = sync_flag;
    ctrl_view[rtccr_pkg::HALF_BIT] = half_reg;
  end

  // One read at a time; data registered with the answer
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= rtccr_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID & ~rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      unique case (S_AXI_ARADDR)
        rtccr_pkg::CTRL_OFS:
        begin
          rdata_reg <= ctrl_view;
          rresp_reg <= rtccr_pkg::RESP_OKAY;
        end
        rtccr_pkg::TIME_OFS:
        begin
          rdata_reg <= time_reg;
          rresp_reg <= rtccr_pkg::RESP_OKAY;
        end
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= rtccr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (S_AXI_RREADY)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Run control
  // ==========================================================
  assign on_bit = ctrl_reg[rtccr_pkg::ON_BIT];
  // Idle stop models the gated bus clock by freezing the timebase
  assign frozen = IDLE_MODE & ctrl_reg[rtccr_pkg::STOP_WHEN_IDLE_BIT];
  assign run = on_bit & ~frozen & TB_SRC_ACTIVE;
  assign tick_in = TB_TICK & run;
  assign trim = ctrl_reg[rtccr_pkg::TRIM_LSB +: rtccr_pkg::TRIM_W];

  // ==========================================================
  // Drift trim
  // ==========================================================
  // Swallow a real tick while removal pending; insert a tick in a
  // quiet cycle while addition pending. Inserted ticks need idle
  // cycles between real ticks, which the fast bus clock provides.
  always_comb
  begin
    if (tick_in)
      eff_tick = (sub_cnt_reg == 10'h000);
    else
      eff_tick = run & (add_cnt_reg != 10'h000);
  end

  // Load correction once per minute, then pay it off tick by tick
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST | ~on_bit)
    begin
      add_cnt_reg <= 10'h000;
      sub_cnt_reg <= 10'h000;
    end
    else if (min_wrap)
    begin
      if (trim[rtccr_pkg::TRIM_W - 1])
      begin
        add_cnt_reg <= 10'h000;
        sub_cnt_reg <= 10'(-trim);
      end
      else
      begin
        add_cnt_reg <= trim;
        sub_cnt_reg <= 10'h000;
      end
    end
    else
    begin
      if (tick_in & (sub_cnt_reg != 10'h000))
        sub_cnt_reg <= sub_cnt_reg - 10'h001;
      if (~tick_in & run & (add_cnt_reg != 10'h000))
        add_cnt_reg <= add_cnt_reg - 10'h001;
    end
  end

  // ==========================================================
  // Half second and minute timebase
  // ==========================================================
  assign half_wrap = eff_tick & (pre_reg == 32'(TICKS_HALF - 1));
  assign min_wrap = half_wrap &
    (halves_reg == 7'(rtccr_pkg::HALVES_PER_MIN - 1));
  // Warn software shortly before the time fields roll over
  assign sync_flag = run &
    (pre_reg >= 32'(SYNC_FROM));

  // Tick prescaler up to one half second
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST | ~on_bit)
      pre_reg <= 32'h0000_0000;
    else if (half_wrap)
      pre_reg <= 32'h0000_0000;
    else if (eff_tick)
      pre_reg <= pre_reg + 32'h0000_0001;
  end

  // Half second counter marking each minute
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST | ~on_bit)
      halves_reg <= 7'h00;
    else if (min_wrap)
      halves_reg <= 7'h00;
    else if (half_wrap)
      halves_reg <= halves_reg + 7'h01;
  end

  // Half second phase; a seconds write restarts the phase
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST)
      half_reg <= 1'b0;
    else if (sec_write)
      half_reg <= 1'b0;
    else if (half_wrap)
      half_reg <= ~half_reg;
  end

  // ==========================================================
  // Output pin
  // ==========================================================
  // Registered so the pin never glitches on select changes
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      RTC_PIN <= 1'b0;
    else if (~ctrl_reg[rtccr_pkg::OE_BIT])
      RTC_PIN <= 1'b0;
    else if (ctrl_reg[rtccr_pkg::OSEL_BIT])
      RTC_PIN <= half_reg;
    else
      RTC_PIN <= ALARM_PULSE;
  end

  // Corrected tick for the time and date counters outside
  always_ff @(posedge CLK)
  begin
    if (SYS_RST | WARM_RST)
      TIMEBASE_TICK <= 1'b0;
    else
      TIMEBASE_TICK <= eff_tick;
  end

endmodule

// ### rtccr_chk.sv
`timescale 1ns/10ps
// ==========================================================
// Port checks for the clock control register block
module rtccr_chk (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WARM_RST,
  input wire logic RTC_PIN,
  input wire logic TIMEBASE_TICK,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID
);
  logic wrote_reg; // Some write has been answered
  logic [3:0] ar_reg; // Address of the read in flight
  // ==========================================================
  // Helper state
  // Until software writes, neither pin nor tick may leave the block
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      wrote_reg <= 1'b0;
    else if (S_AXI_BVALID)
      wrote_reg <= 1'b1;
  end
  // Remember the read address so read data can be judged
  always_ff @(posedge CLK)
  begin
    if (S_AXI_ARVALID && S_AXI_ARREADY)
      ar_reg <= S_AXI_ARADDR;
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST || WARM_RST);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  rst_quiet_a:
    assert property (disable iff (1'b0) SYS_RST |=> !S_AXI_BVALID &&
      !S_AXI_RVALID && !RTC_PIN && !TIMEBASE_TICK)
    else $error("outputs active after power-on reset");
  wr_answer_a:
    assert property (wr_taken |=> !S_AXI_AWREADY ##1 S_AXI_BVALID)
    else $error("write answer late or address not held");
  b_once_a:
    assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answered twice");
  rd_answer_a:
    assert property (rd_taken |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  rd_bad_a:
    assert property (rd_taken and S_AXI_ARADDR > 4'h4 |=>
      S_AXI_RRESP == rtccr_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  rd_zero_a:
    assert property (S_AXI_RVALID && ar_reg == rtccr_pkg::CTRL_OFS |->
      (S_AXI_RDATA & 32'hFC00_5F30) == 32'h0)
    else $error("unused control bits not zero");
  pin_quiet_a:
    assert property (!wrote_reg |-> !RTC_PIN)
    else $error("output pin active before any write");
  tick_quiet_a:
    assert property (!wrote_reg |-> !TIMEBASE_TICK)
    else $error("tick while module never enabled");
endmodule
bind rtccr_top rtccr_chk i_chk (.*);

// ### tb.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the clock control register block
`define CHK(nm, e, g) \
  begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module tb;
  localparam logic [3:0] CT = rtccr_pkg::CTRL_OFS; // Control
  logic CLK, SYS_RST, WARM_RST, IDLE_MODE, SYS_SEQ_OPEN, TB_SRC_ACTIVE;
  logic TB_TICK, ALARM_PULSE, RTC_PIN, TIMEBASE_TICK;
  logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY;
  int n_errors, check_count, n_out;
  // Short half second keeps a minute at 1920 ticks
  rtccr_top #(.TICKS_HALF(16)) i_dut (.*);
  // ==========================================================
  // Clock and tick counter
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) if (TIMEBASE_TICK) n_out++;
  // ==========================================================
  // Bus tasks; each starts just after a clock edge
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
    input logic [3:0] s);
    int n;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    // Each channel drops once its own ready was seen
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 99);
    r = S_AXI_BRESP;
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 99);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
  endtask
  // One timebase pulse every fourth cycle
  task automatic tk(input int n);
    repeat (n)
    begin
      TB_TICK <= 1'b1;
      @(posedge CLK);
      TB_TICK <= 1'b0;
      repeat (3) @(posedge CLK);
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(CT);
    `CHK("ctrl", rtccr_pkg::CTRL_RST, d)
    rd(rtccr_pkg::TIME_OFS);
    `CHK("time", rtccr_pkg::TIME_RST, d)
  endtask
  // All ones with the sequence closed: lock holds, holes stay zero
  task automatic t_lock();
    wr(CT, 32'hFFFF_FFFF, 4'hF);
    rd(CT);
    `CHK("locked", 32'h03FF_2081, d & 32'hFFFF_FFF9)
    SYS_SEQ_OPEN <= 1'b1;
    wr(CT, 32'h0000_0008, 4'hF);
    wr(CT, 32'h0000_8008, 4'hF);
    rd(CT);
    `CHK("on", 32'h0000_8048, d & 32'hFFFF_FFF9)
  endtask
  task automatic t_map();
    rd(4'h8);
    `CHK("bad rd", {rtccr_pkg::RESP_SLVERR, 32'h0}, {r, d})
    wr(4'hC, 32'hFFFF_FFFF, 4'hF);
    `CHK("bad wr", rtccr_pkg::RESP_SLVERR, r)
  endtask
  // Disable clears the minute, then 2500 ticks cross one boundary
  task automatic t_trim(input logic [9:0] t, input int e);
    wr(CT, {6'h00, t, 16'h0008}, 4'hF);
    @(posedge CLK); // Quiet cycle after disabling the module
    wr(CT, {6'h00, t, 16'h8008}, 4'hF);
    n_out = 0;
    tk(2500);
    repeat (700) @(posedge CLK);
    `CHK("ticks", e, n_out)
  endtask
  task automatic t_half();
    int n;
    wr(CT, 32'h0000_8089, 4'hF);
    n = 0;
    d = 32'h0;
    while (d[1] !== 1'b1 && n < 40)
    begin
      tk(1);
      rd(CT);
      n++;
    end
    `CHK("pin sec", 1'b1, RTC_PIN)
    wr(rtccr_pkg::TIME_OFS, 32'h0000_0000, 4'h2);
    rd(CT);
    `CHK("half", 1'b0, d[1])
    ALARM_PULSE <= 1'b1;
    wr(CT, 32'h0000_8009, 4'hF);
    repeat (2) @(posedge CLK);
    `CHK("pin alarm", 1'b1, RTC_PIN)
    wr(CT, 32'h0000_8008, 4'hF);
    repeat (2) @(posedge CLK);
    `CHK("pin off", 1'b0, RTC_PIN)
  endtask
  task automatic t_run();
    wr(CT, 32'h0000_A008, 4'hF);
    IDLE_MODE <= 1'b1;
    @(posedge CLK);
    rd(CT);
    `CHK("idle stop", 1'b0, d[6])
    `CHK("sync stop", 1'b0, d[2])
    wr(CT, 32'h0000_8008, 4'hF);
    rd(CT);
    `CHK("idle run", 1'b1, d[6])
    `CHK("sync run", 1'b1, d[2])
    TB_SRC_ACTIVE <= 1'b0;
    @(posedge CLK);
    rd(CT);
    `CHK("no source", 1'b0, d[6])
    TB_SRC_ACTIVE <= 1'b1;
    IDLE_MODE <= 1'b0;
    @(posedge CLK);
  endtask
  // Warm reset must leave the control word alone
  task automatic t_warm();
    WARM_RST <= 1'b1;
    @(posedge CLK);
    WARM_RST <= 1'b0;
    @(posedge CLK);
    rd(CT);
    `CHK("warm", 32'h0000_8048, d & 32'hFFFF_FFF9)
  endtask
  task automatic conclude();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence; ready lines stay high throughout
  initial
  begin
    {SYS_RST, S_AXI_BREADY, S_AXI_RREADY, TB_SRC_ACTIVE} = 4'hF;
    {WARM_RST, IDLE_MODE, SYS_SEQ_OPEN, TB_TICK, ALARM_PULSE} = 5'h00;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = 3'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB} = 12'h000;
    S_AXI_WDATA = 32'h0;
    n_errors = 0;
    check_count = 0;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_lock();
    t_map();
    t_trim(10'h1FF, 3011);
    t_trim(10'h200, 1988);
    t_trim(10'h3FF, 2499);
    t_trim(10'h001, 2501);
    t_half();
    t_run();
    t_warm();
    conclude();
  end
  // Watchdog: about 80000 cycles, well past the planned run
  initial
  begin
    #4_000_000;
    n_errors++;
    conclude();
  end
endmodule
